// ---- pkg/lsd_defines.svh ----
`ifndef LSD_DEFINES_SVH
`define LSD_DEFINES_SVH
// Offsets from the die-to-die register base
`define LSD_OFS_CONTROL      8'h30
`define LSD_OFS_STATUS       8'h31
`define LSD_OFS_UNLOCK       8'h32
// Global bases for the two access styles
`define LSD_BASE_BLOCKING    12'h200
`define LSD_BASE_NONBLOCKING 12'h300
// Control register field positions
`define LSD_CTL_OT_IRQ_EN    7
`define LSD_CTL_DRV2_CHSEL   5
`define LSD_CTL_DRV1_CHSEL   4
`define LSD_CTL_DRV2_PWM_EN  3
`define LSD_CTL_DRV1_PWM_EN  2
`define LSD_CTL_DRV2_EN      1
`define LSD_CTL_DRV1_EN      0
// Writable bits of each register
`define LSD_CTL_WMASK        8'hbf
`define LSD_UNLOCK_WMASK     8'h0f
// Reset values and the unlock key
`define LSD_CTL_RESET        8'h00
`define LSD_UNLOCK_RESET     8'h00
`define LSD_UNLOCK_KEY       4'h5
`endif

// ---- pkg/lsd_pkg.sv ----
package lsd_pkg;
    // Register access request from the die-to-die interface
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } lsd_req_t;
    // Analog status from the power switches
    typedef struct packed {
        logic overtemp;
        logic drv2_cl;
        logic drv1_cl;
        logic drv2_ol;
        logic drv1_ol;
    } lsd_analog_t;
    // Which register an address selects
    typedef enum logic [1:0] {
        LSD_SEL_NONE,
        LSD_SEL_CONTROL,
        LSD_SEL_STATUS,
        LSD_SEL_UNLOCK
    } lsd_sel_t;
endpackage

// ---- rtl/lsd_ctrl.sv ----
`timescale 1ns/1ps
`include "lsd_defines.svh"
// Summary of operation
// - Control bit 7 lets over-temperature raise an interrupt; shutdown happens regardless.
// - Control bit 5 picks PWM channel 0 or 1 for driver 2.
// - Control bit 4 picks PWM channel 0 or 1 for driver 1.
// - Control bit 3 gates driver 2 with its chosen PWM channel.
// - Control bit 2 gates driver 1 with its chosen PWM channel.
// - Control bits 1 and 0 switch drivers, effective only after unlock.
// - Unlock field bits 3-0 enables control only when holding 0x5.
// - After reset or regulator over-voltage, enables ignored until key rewritten.
// - Status bit 7 shows over-temperature; both drivers forced off meanwhile.
// - Reading status clears the pending over-temperature interrupt flag.
// - Status bits 3 and 2 show current limitation on drivers 2 and 1.
// - Status bits 1 and 0 show open load on drivers 2 and 1.
// - Open load is never reported while a driver is off.
// - Drivers work only in Normal mode; held off in Sleep or Stop.
// - Control, status, unlock registers sit at offsets 0x30, 0x31, 0x32.
// - Offsets decode relative to 0x0200 blocking and 0x300 non-blocking bases.
// - Regulator over-voltage clears both driver enable bits.
// - After over-temperature, a control write re-enables drivers once condition ends.
module lsd_ctrl
    import lsd_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire lsd_req_t    i_req,
    input  wire lsd_analog_t i_analog,
    input  wire logic        i_normal_mode,
    input  wire logic        i_vreg_ov,
    input  wire logic        i_pwm0,
    input  wire logic        i_pwm1,
    output logic [7:0]       o_rdata,
    output logic             o_rvalid,
    output logic             o_drv1,
    output logic             o_drv2,
    output logic             o_overtemp_irq
);
    logic [7:0] control_reg_q;
    logic [7:0] control_reg_d;
    logic [7:0] unlock_register_q;
    logic       unlocked_q;
    logic       unlocked_d;
    logic       ot_latched_q;
    logic       ot_latched_d;
    logic       irq_flag_q;
    logic       irq_flag_d;
    logic       ot_prev_q;
    logic [7:0] rdata_q;
    logic       rvalid_q;
    logic       ol1;
    logic       ol2;

    // Address decode against both access bases
    function automatic lsd_sel_t decode(input logic [11:0] a);
        logic [11:0] base;
        logic [7:0]  ofs;
        base = {a[11:8], 8'h00};
        ofs  = a[7:0];
        if (base != `LSD_BASE_BLOCKING && base != `LSD_BASE_NONBLOCKING)
            return LSD_SEL_NONE;
        if (ofs == `LSD_OFS_CONTROL) return LSD_SEL_CONTROL;
        if (ofs == `LSD_OFS_STATUS)  return LSD_SEL_STATUS;
        if (ofs == `LSD_OFS_UNLOCK)  return LSD_SEL_UNLOCK;
        return LSD_SEL_NONE;
    endfunction

    wire lsd_sel_t sel      = decode(i_req.addr);
    wire           wr_ctl   = i_req.wr & (sel == LSD_SEL_CONTROL);
    wire           wr_unl   = i_req.wr & (sel == LSD_SEL_UNLOCK);
    wire           rd_stat  = i_req.rd & (sel == LSD_SEL_STATUS);
    wire           ot       = i_analog.overtemp;
    wire           ot_rise  = ot & ~ot_prev_q;
    wire           key_ok   = (i_req.wdata[3:0] == `LSD_UNLOCK_KEY);
    wire [7:0]     status_w = {ot, 3'h0, i_analog.drv2_cl, i_analog.drv1_cl,
                               ol2, ol1};

    // Control register; over-voltage clears enables and wins over a write
    always_comb
    begin
        control_reg_d = control_reg_q;
        if (wr_ctl)
            control_reg_d = i_req.wdata & `LSD_CTL_WMASK;
        if (i_vreg_ov)
        begin
            control_reg_d[`LSD_CTL_DRV2_EN] = 1'b0;
            control_reg_d[`LSD_CTL_DRV1_EN] = 1'b0;
        end
    end

    // Unlock is lost on over-voltage and regained by writing the key once
    always_comb
    begin
        unlocked_d = unlocked_q;
        if (wr_unl)
            unlocked_d = key_ok;
        if (i_vreg_ov)
            unlocked_d = 1'b0;
    end

    // Shutdown latch holds until a control write after the condition ends
    always_comb
    begin
        ot_latched_d = ot_latched_q;
        if (wr_ctl && !ot)
            ot_latched_d = 1'b0;
        if (ot)
            ot_latched_d = 1'b1;
    end

    // Interrupt flag: new event beats a clearing status read
    always_comb
    begin
        irq_flag_d = irq_flag_q;
        if (rd_stat)
            irq_flag_d = 1'b0;
        if (ot_rise)
            irq_flag_d = 1'b1;
    end

    wire enables_ok = unlocked_q & i_normal_mode & ~ot_latched_q;
    wire force_off  = ~enables_ok | ot;

    // Named control fields feed both gates and the checks below; the interrupt enable feeds only the checks
    wire overtemp_irq_enable     = control_reg_q[`LSD_CTL_OT_IRQ_EN];
    wire drv2_pwm_channel_select = control_reg_q[`LSD_CTL_DRV2_CHSEL];
    wire drv1_pwm_channel_select = control_reg_q[`LSD_CTL_DRV1_CHSEL];
    wire drv2_pwm_enable         = control_reg_q[`LSD_CTL_DRV2_PWM_EN];
    wire drv1_pwm_enable         = control_reg_q[`LSD_CTL_DRV1_PWM_EN];
    wire driver2_enable          = control_reg_q[`LSD_CTL_DRV2_EN];
    wire driver1_enable          = control_reg_q[`LSD_CTL_DRV1_EN];

    lsd_drive_gate u_gate1 (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_enable    (driver1_enable),
        .i_pwm_en    (drv1_pwm_enable),
        .i_chsel     (drv1_pwm_channel_select),
        .i_pwm0      (i_pwm0),
        .i_pwm1      (i_pwm1),
        .i_force_off (force_off),
        .i_open_load (i_analog.drv1_ol),
        .o_drive     (o_drv1),
        .o_open_load (ol1)
    );

    lsd_drive_gate u_gate2 (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_enable    (driver2_enable),
        .i_pwm_en    (drv2_pwm_enable),
        .i_chsel     (drv2_pwm_channel_select),
        .i_pwm0      (i_pwm0),
        .i_pwm1      (i_pwm1),
        .i_force_off (force_off),
        .i_open_load (i_analog.drv2_ol),
        .o_drive     (o_drv2),
        .o_open_load (ol2)
    );

    // Read mux; unmapped addresses read zero
    wire [7:0] rd_mux = (sel == LSD_SEL_CONTROL) ? control_reg_q :
                        (sel == LSD_SEL_STATUS)  ? status_w :
                        (sel == LSD_SEL_UNLOCK)  ? unlock_register_q : 8'h00;

    // State registers
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            control_reg_q     <= `LSD_CTL_RESET;
            unlock_register_q <= `LSD_UNLOCK_RESET;
            unlocked_q        <= 1'b0;
            ot_latched_q      <= 1'b0;
            irq_flag_q        <= 1'b0;
            ot_prev_q         <= 1'b0;
            rdata_q           <= 8'h00;
            rvalid_q          <= 1'b0;
        end
        else
        begin
            control_reg_q <= control_reg_d;
            if (wr_unl)
                unlock_register_q <= i_req.wdata & `LSD_UNLOCK_WMASK;
            unlocked_q   <= unlocked_d;
            ot_latched_q <= ot_latched_d;
            irq_flag_q   <= irq_flag_d;
            ot_prev_q    <= ot;
            rdata_q      <= i_req.rd ? rd_mux : 8'h00;
            rvalid_q     <= i_req.rd;
        end
    end

    // Interrupt output gated by the enable bit, registered
    logic irq_q;
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            irq_q <= 1'b0;
        else
            irq_q <= irq_flag_d & control_reg_d[`LSD_CTL_OT_IRQ_EN];
    end

    assign o_rdata        = rdata_q;
    assign o_rvalid       = rvalid_q;
    assign o_overtemp_irq = irq_q;

    // Lock, key, mode and gating checks
    AST_NO_DRIVE_LOCKED: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) !unlocked_q |=> !o_drv1 && !o_drv2)
        else $error("driver on while locked");
    AST_KEY_UNLOCKS: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) wr_unl && key_ok && !i_vreg_ov |=> unlocked_q)
        else $error("key not taken");
    AST_BADKEY_LOCKS: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) wr_unl && !key_ok |=> !unlocked_q)
        else $error("bad key unlocked");
    AST_LOCK_HOLDS: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) !unlocked_q && !(wr_unl && key_ok) |=> !unlocked_q)
        else $error("unlocked without key");
    AST_OV_CLEARS: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) i_vreg_ov |=> control_reg_q[1:0] == 2'b00 && !unlocked_q)
        else $error("ov kept enables");
    AST_SLEEP_OFF: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) !i_normal_mode |=> !o_drv1 && !o_drv2)
        else $error("driver on outside normal");
    AST_DRV1_OFF_BIT: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) !driver1_enable |=> !o_drv1)
        else $error("driver 1 on with its bit clear");
    AST_DRV2_OFF_BIT: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) !driver2_enable |=> !o_drv2)
        else $error("driver 2 on with its bit clear");
    AST_DRV1_GATE: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) enables_ok && !ot && driver1_enable |=>
        o_drv1 == (!$past(drv1_pwm_enable) ||
        ($past(drv1_pwm_channel_select) ? $past(i_pwm1) : $past(i_pwm0))))
        else $error("driver 1 gating wrong");
    AST_DRV2_GATE: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) enables_ok && !ot && driver2_enable |=>
        o_drv2 == (!$past(drv2_pwm_enable) ||
        ($past(drv2_pwm_channel_select) ? $past(i_pwm1) : $past(i_pwm0))))
        else $error("driver 2 gating wrong");

    // Over-temperature, shutdown latch and interrupt checks
    AST_OT_OFF: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) ot |=> !o_drv1 && !o_drv2)
        else $error("driver on in overtemp");
    AST_OT_LATCHES: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) ot |=> ot_latched_q)
        else $error("shutdown not latched");
    AST_LATCH_OFF: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) ot_latched_q |=> !o_drv1 && !o_drv2)
        else $error("driver on before rewrite");
    AST_LATCH_HOLDS: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) ot_latched_q && !wr_ctl |=> ot_latched_q)
        else $error("shutdown released without write");
    AST_REWRITE_CLEARS: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) wr_ctl && !ot |=> !ot_latched_q)
        else $error("rewrite did not release");
    AST_IRQ_SET: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) ot_rise |=> irq_flag_q)
        else $error("flag not set");
    AST_IRQ_RAISE: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) ot_rise && overtemp_irq_enable && !wr_ctl |=>
        o_overtemp_irq)
        else $error("enabled irq missing");
    AST_IRQ_MASK: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) !overtemp_irq_enable |-> !o_overtemp_irq)
        else $error("masked irq");
    AST_RD_CLEARS: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) rd_stat && !ot_rise |=> !irq_flag_q)
        else $error("flag not cleared");
    AST_HELD_OT_NO_REFIRE: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) ot && ot_prev_q && !irq_flag_q |=> !irq_flag_q)
        else $error("held condition set flag again");

    // Register access and status checks
    AST_RVALID: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) i_req.rd |=> o_rvalid)
        else $error("read not answered");
    AST_RDATA_IDLE: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) !o_rvalid |-> o_rdata == 8'h00)
        else $error("read data outside answer");
    AST_UNMAPPED_ZERO: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) i_req.rd && sel == LSD_SEL_NONE |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_NO_ADDR_HIT: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) i_req.wr && sel == LSD_SEL_NONE && !i_vreg_ov |=>
        $stable(control_reg_q) && $stable(unlock_register_q))
        else $error("unmapped write landed");
    AST_CTL_READ: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) i_req.rd && sel == LSD_SEL_CONTROL |=>
        o_rdata == $past(control_reg_q))
        else $error("control read wrong");
    AST_CTL_WRITE: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) wr_ctl && !i_vreg_ov |=>
        control_reg_q == ($past(i_req.wdata) & `LSD_CTL_WMASK))
        else $error("control write wrong");
    AST_UNL_WRITE: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) wr_unl |=>
        unlock_register_q == ($past(i_req.wdata) & `LSD_UNLOCK_WMASK))
        else $error("unlock write wrong");
    AST_RSVD_ZERO: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) control_reg_q[6] == 1'b0 && unlock_register_q[7:4] == 4'h0)
        else $error("reserved set");
    AST_STATUS_RSVD: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) rd_stat |=> o_rdata[6:4] == 3'h0)
        else $error("status reserved set");
    AST_STATUS_OT: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) rd_stat |=> o_rdata[7] == $past(ot))
        else $error("status overtemp wrong");
    AST_STATUS_CL: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) rd_stat |=>
        o_rdata[3:2] == {$past(i_analog.drv2_cl), $past(i_analog.drv1_cl)})
        else $error("status limit wrong");
    AST_STATUS_OL: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) rd_stat |=> o_rdata[1:0] == {$past(ol2), $past(ol1)})
        else $error("status open load wrong");
    AST_OL_OFF: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) !o_drv1 |-> !ol1)
        else $error("open load while off");
    AST_OL_OFF2: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) !o_drv2 |-> !ol2)
        else $error("open load while driver 2 off");
endmodule

// ---- rtl/lsd_drive_gate.sv ----
`timescale 1ns/1ps
`include "lsd_defines.svh"
// One driver's output path: enable, optional PWM gating, forced-off conditions
module lsd_drive_gate
    import lsd_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_enable,
    input  wire logic i_pwm_en,
    input  wire logic i_chsel,
    input  wire logic i_pwm0,
    input  wire logic i_pwm1,
    input  wire logic i_force_off,
    input  wire logic i_open_load,
    output logic      o_drive,
    output logic      o_open_load
);
    logic drive_q;
    logic drive_d;
    logic ol_q;
    wire  pwm_sel = i_chsel ? i_pwm1 : i_pwm0;

    // Modulation only when the PWM bit is set
    assign drive_d = i_enable & ~i_force_off & (~i_pwm_en | pwm_sel);

    // Open load only reported while the driver is on
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            drive_q <= 1'b0;
            ol_q    <= 1'b0;
        end
        else
        begin
            drive_q <= drive_d;
            ol_q    <= i_open_load & drive_d;
        end
    end

    assign o_drive     = drive_q;
    assign o_open_load = ol_q;
endmodule

// ---- tb/low_side_driver_control_tb.sv ----
`timescale 1ns/1ps
`include "lsd_defines.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module low_side_driver_control_tb
    import lsd_pkg::*;
;
    localparam logic [11:0] A_CTL = `LSD_BASE_BLOCKING + `LSD_OFS_CONTROL;
    localparam logic [11:0] A_ST  = `LSD_BASE_BLOCKING + `LSD_OFS_STATUS;
    localparam logic [11:0] A_UL  = `LSD_BASE_BLOCKING + `LSD_OFS_UNLOCK;
    logic        i_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    lsd_req_t    req = '0;
    lsd_analog_t ana;
    logic        normal = 1'b1;
    logic        vreg_ov = 1'b0;
    logic        pwm0 = 1'b1;
    logic        pwm1 = 1'b0;
    logic        hot = 1'b0;
    logic [1:0]  open_q = 2'b00;
    logic [1:0]  limit_q = 2'b00;
    logic [7:0]  o_rdata;
    logic        o_rvalid;
    logic        o_drv1;
    logic        o_drv2;
    logic        o_overtemp_irq;
    int          n_errors = 0;
    int          checks_done = 0;

    always #4 i_clk = ~i_clk;

    lsd_ctrl dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(req), .i_analog(ana),
        .i_normal_mode(normal), .i_vreg_ov(vreg_ov), .i_pwm0(pwm0), .i_pwm1(pwm1),
        .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_drv1(o_drv1), .o_drv2(o_drv2),
        .o_overtemp_irq(o_overtemp_irq));

    lsd_switch_model model (.i_drv1(o_drv1), .i_drv2(o_drv2), .i_hot(hot),
        .i_open(open_q), .i_limit(limit_q), .o_analog(ana));

    // One-cycle write strobe, launched and dropped on rising edges
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        req <= '0;
    endtask

    // Read strobe; data is looked at in the single cycle it stands
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        @(posedge i_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk);
        req <= '0;
        #1;
        `CHK({o_rvalid, o_rdata}, {1'b1, e})
    endtask

    // Let a control change reach the registered gate outputs
    task automatic settle();
        repeat (3) @(posedge i_clk);
        #1;
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the roughly 190 cycles the tests need
    initial
    begin
        repeat (5000) @(posedge i_clk);
        n_errors++;
        final_report();
    end

    initial
    begin
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd_chk(A_CTL, 8'h00);
        rd_chk(A_ST, 8'h00);
        rd_chk(A_UL, 8'h00);
        wr(A_CTL, 8'hff);
        rd_chk(A_CTL, 8'hbf);
        rd_chk(12'h330, 8'hbf);
        rd_chk(12'h233, 8'h00);
        settle();
        `CHK({o_drv2, o_drv1}, 2'b00)
        wr(A_UL, 8'ha5);
        rd_chk(A_UL, 8'h05);
        $display("test registers done");
        for (int i = 0; i < 16; i++)
        begin
            wr(A_CTL, {2'b00, i[3:0], 2'b11});
            settle();
            `CHK({o_drv2, o_drv1}, {~(i[1] & i[3]), ~(i[0] & i[2])})
        end
        wr(A_CTL, 8'h03);
        settle();
        `CHK({o_drv2, o_drv1}, 2'b11)
        wr(A_UL, 8'h06);
        settle();
        `CHK({o_drv2, o_drv1}, 2'b00)
        wr(A_UL, 8'h05);
        settle();
        `CHK({o_drv2, o_drv1}, 2'b11)
        $display("test gating done");
        wr(A_CTL, 8'h03);
        open_q <= 2'b11;
        limit_q <= 2'b11;
        settle();
        rd_chk(A_ST, 8'h0f);
        wr(A_CTL, 8'h0f);
        pwm0 <= 1'b0;
        settle();
        rd_chk(A_ST, 8'h00);
        pwm0 <= 1'b1;
        open_q <= 2'b00;
        limit_q <= 2'b00;
        $display("test status done");
        wr(A_CTL, 8'h83);
        hot <= 1'b1;
        settle();
        `CHK({o_overtemp_irq, o_drv2, o_drv1}, 3'b100)
        rd_chk(A_ST, 8'h80);
        settle();
        `CHK(o_overtemp_irq, 1'b0)
        hot <= 1'b0;
        settle();
        `CHK({o_drv2, o_drv1}, 2'b00)
        wr(A_CTL, 8'h03);
        settle();
        `CHK({o_drv2, o_drv1}, 2'b11)
        hot <= 1'b1;
        settle();
        `CHK({o_overtemp_irq, o_drv2, o_drv1}, 3'b000)
        hot <= 1'b0;
        wr(A_CTL, 8'h03);
        $display("test overtemp done");
        normal <= 1'b0;
        settle();
        `CHK({o_drv2, o_drv1}, 2'b00)
        normal <= 1'b1;
        settle();
        `CHK({o_drv2, o_drv1}, 2'b11)
        vreg_ov <= 1'b1;
        @(posedge i_clk);
        vreg_ov <= 1'b0;
        rd_chk(A_CTL, 8'h00);
        wr(A_CTL, 8'h03);
        settle();
        `CHK({o_drv2, o_drv1}, 2'b00)
        wr(A_UL, 8'h05);
        settle();
        `CHK({o_drv2, o_drv1}, 2'b11)
        $display("test modes done");
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd_chk(A_CTL, 8'h00);
        rd_chk(A_UL, 8'h00);
        wr(A_CTL, 8'h03);
        settle();
        `CHK({o_overtemp_irq, o_drv2, o_drv1}, 3'b000)
        wr(A_UL, 8'h05);
        settle();
        `CHK({o_drv2, o_drv1}, 2'b11)
        $display("test reset done");
        final_report();
    end
endmodule

// ---- tb/lsd_switch_model.sv ----
`timescale 1ns/1ps
// Behavioural model of the two analog low-side switches and their relay loads
module lsd_switch_model
    import lsd_pkg::*;
(
    input  wire logic        i_drv1,
    input  wire logic        i_drv2,
    input  wire logic        i_hot,
    input  wire logic [1:0]  i_open,
    input  wire logic [1:0]  i_limit,
    output lsd_analog_t      o_analog
);
    // Die temperature does not depend on the gates
    assign o_analog.overtemp = i_hot;
    // Limiting needs load current, so it only shows while a gate is on
    assign o_analog.drv2_cl  = i_limit[1] & i_drv2;
    assign o_analog.drv1_cl  = i_limit[0] & i_drv1;
    // An off switch carries no current and looks open, so the digital side must mask it
    assign o_analog.drv2_ol  = i_open[1] | ~i_drv2;
    assign o_analog.drv1_ol  = i_open[0] | ~i_drv1;
endmodule
